// ---- rtl/cdl_pkg.sv ----
// Package with constants, types and field layouts for the cyclic data link refresh block.
// Functional notes
// - Refresh every node from lowest to highest participating node number.
// - Nodes outside the participating span are not refreshed; with manual tables their words stay free.
// - With automatic tables, nodes inside the span are refreshed even when absent; manual tables skip absent nodes.
// - Cycle time is 5 to 255 ms; zero means self-generated.
// - Link-relay count 1 to 64; dash is non-participant; zero is receive-only.
// - Data-memory count 1 to 254; dash is non-participant; zero is receive-only.
// - Participant count and numbers derive from the per-node word counts.
// - Refresh parameters accept only nodes marked participating.
// - A start word locates the status region, one flag group per node.
// - Link-relay start word is limited to 0 to 63.
// - Data-memory start word limit is 999, 5999 or 4095 by host family.
// - Only listed local and linked nodes' words are transferred.
// - Refresh word counts must equal the common parameter counts.
// - Common parameters can be copied to all designated nodes.
// - Automatic allocation follows node number and 4, 8, 16 or 32 link-relay words or 8, 16, 32 or 64 data-memory words per node.
`default_nettype none
package cdl_pkg;
  localparam int unsigned NODE_MAX = 62;
  localparam int unsigned NODE_W = 6;
  localparam logic [7:0] CNT_DASH = 8'h_ff;
  localparam logic [7:0] LR_CNT_MAX = 8'h_40;
  localparam logic [7:0] DM_CNT_MAX = 8'h_fe;
  localparam logic [7:0] CYC_MIN_MS = 8'h_05;
  localparam logic [7:0] CYC_AUTO_MS = 8'h_00;
  localparam logic [15:0] LR_START_MAX = 16'h_003f;
  localparam logic [15:0] DM_START_MAX0 = 16'h_03e7;
  localparam logic [15:0] DM_START_MAX1 = 16'h_176f;
  localparam logic [15:0] DM_START_MAX2 = 16'h_0fff;
  localparam logic [15:0] REDUCED_SPAN = 16'h_0396;
  localparam logic [15:0] TOTAL_MAX = 16'h_0b96;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned MS_CYCLES = CLK_MHZ * 1000;
  localparam logic [7:0] CYC_DERIVED_BASE = 8'h_05;
  // Register addresses on the plain port.
  localparam logic [7:0] A_CTRL = 8'h_00;
  localparam logic [7:0] A_CYCLE = 8'h_01;
  localparam logic [7:0] A_LR_START = 8'h_02;
  localparam logic [7:0] A_DM_START = 8'h_03;
  localparam logic [7:0] A_STAT_START = 8'h_04;
  localparam logic [7:0] A_STATUS = 8'h_05;
  localparam logic [7:0] A_SPAN = 8'h_06;
  localparam logic [7:0] A_NODE_SEL = 8'h_07;
  localparam logic [7:0] A_NODE_CNT = 8'h_08;
  localparam logic [7:0] A_NODE_REF = 8'h_09;
  localparam logic [7:0] A_AUTO = 8'h_0a;
  localparam logic [7:0] A_RANGE = 8'h_0b;
  // Control register bits.
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_FAMILY = 1;
  localparam int unsigned CTRL_COPY = 3;
  localparam int unsigned CTRL_REDUCED = 4;
  // Status register bits.
  localparam int unsigned ST_ERR_LR_START = 0;
  localparam int unsigned ST_ERR_DM_START = 1;
  localparam int unsigned ST_ERR_CYCLE = 2;
  localparam int unsigned ST_ERR_NODE = 3;
  localparam int unsigned ST_ERR_CNT = 4;
  localparam int unsigned ST_ERR_REDUCED = 5;
  localparam int unsigned ST_MANUAL = 6;
  localparam int unsigned ST_BUSY = 7;

  typedef struct packed {
    logic [NODE_W-1:0] node;
    logic is_dm;
    logic [15:0] word_addr;
    logic [15:0] status_addr;
  } cdl_req_s;

  typedef enum logic [1:0] {
    CDL_IDLE = 2'b00,
    CDL_SCAN = 2'b01,
    CDL_WAIT = 2'b10
  } cdl_state_e;
endpackage
`default_nettype wire

// ---- rtl/cdl_fifo2.sv ----
// Two-entry valid/ready buffer for refresh requests.
`default_nettype none
module cdl_fifo2 #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clk, // clock
  input wire logic i_reset, // synchronous reset
  input wire logic i_valid, // input valid
  output logic o_ready, // room available
  input wire logic [WIDTH-1:0] i_data, // input word
  output logic o_valid, // output valid
  input wire logic i_ready, // drain ready
  output logic [WIDTH-1:0] o_data // output word
);
  logic [WIDTH-1:0] mem_r [2];
  logic rd_r;
  logic wr_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;
  assign push = i_valid && (cnt_r != 2'd2);
  assign pop = o_valid && i_ready;
  assign o_ready = cnt_r != 2'd2;
  assign o_valid = cnt_r != 2'd0;
  assign o_data = mem_r[rd_r];
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_data;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) begin
        wr_r <= ~wr_r;
      end
      if (pop) begin
        rd_r <= ~rd_r;
      end
      cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule // cdl_fifo2
`default_nettype wire

// ---- rtl/cdl_span.sv ----
// Participation decoder: span of lowest to highest participating node.
`default_nettype none
module cdl_span #(
  parameter int unsigned NODES = 62
) (
  input wire logic [NODES-1:0] i_part, // participating flags, bit 0 is node 1
  output logic o_any, // at least one participant
  output logic [5:0] o_low, // lowest participating node index
  output logic [5:0] o_high, // highest participating node index
  output logic [5:0] o_count // number of participants
);
  always_comb begin
    o_any = 1'b0;
    o_low = 6'd0;
    o_high = 6'd0;
    o_count = 6'd0;
    for (int i = NODES - 1; i >= 0; i--) begin
      if (i_part[i]) begin
        o_low = 6'(i);
      end
    end
    for (int i = 0; i < NODES; i++) begin
      if (i_part[i]) begin
        o_high = 6'(i);
        o_any = 1'b1;
        o_count = 6'(o_count + 6'd1);
      end
    end
  end
endmodule // cdl_span
`default_nettype wire

// ---- rtl/cdl_refresh.sv ----
// Top of the cyclic data link refresh block: parameters, checks and refresh scan.
`default_nettype none
module cdl_refresh #(
  parameter int unsigned NODES = 62,
  parameter int unsigned MS_CYC = cdl_pkg::MS_CYCLES
) (
  input wire logic i_clk, // clock
  input wire logic i_reset, // synchronous reset
  input wire logic [7:0] i_addr, // register address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data one cycle after the strobe
  input wire logic i_level, // active operating level
  input wire logic [1:0] i_lvl0_sel, // level0_area_select_low/high
  input wire logic [1:0] i_lvl1_sel, // level1_area_select_low/high
  input wire logic [1:0] i_lvl0_words, // level 0 words-per-node code
  input wire logic [1:0] i_lvl1_words, // level 1 words-per-node code
  output logic o_req_valid, // refresh request valid
  input wire logic i_req_ready, // receiver ready
  output cdl_pkg::cdl_req_s o_req, // refresh request
  output logic o_cycle_tick, // one-cycle pulse at each link cycle start
  output logic o_copy_req, // pulse: copy common parameters to nodes
  output logic o_manual // manual tables selected
);
  logic run_r;
  logic [1:0] family_r;
  logic reduced_r;
  logic [7:0] cycle_ms_r;
  logic [15:0] lr_start_r;
  logic [15:0] dm_start_r;
  logic [15:0] stat_start_r;
  logic [5:0] sel_r;
  logic [7:0] lr_cnt_r [NODES];
  logic [7:0] dm_cnt_r [NODES];
  logic [NODES-1:0] ref_r;
  logic [7:0] err_r;
  logic [31:0] rdata_r;
  logic copy_r;
  logic manual_r;
  logic tick_r;
  logic [31:0] ms_cnt_r;
  logic [7:0] ms_left_r;
  cdl_pkg::cdl_state_e state_r;
  logic [5:0] node_r;
  logic area_r;
  logic [7:0] word_r;
  logic [15:0] lr_base_r;
  logic [15:0] dm_base_r;
  logic [NODES-1:0] part;
  logic span_any;
  logic [5:0] span_low;
  logic [5:0] span_high;
  logic [5:0] span_cnt;
  logic [1:0] sel_now;
  logic [1:0] words_now;
  logic auto_mode;
  logic [7:0] cur_cnt;
  logic [7:0] auto_lr;
  logic [7:0] auto_dm;
  logic buf_ready;
  logic push;
  cdl_pkg::cdl_req_s req;
  logic [7:0] eff_cycle;
  logic [15:0] dm_limit;
  logic [15:0] total;

  function automatic logic is_part(input logic [7:0] lr, input logic [7:0] dm);
    is_part = (lr != cdl_pkg::CNT_DASH) || (dm != cdl_pkg::CNT_DASH);
  endfunction

  function automatic logic cnt_ok(input logic [7:0] c, input logic [7:0] lim);
    cnt_ok = (c == cdl_pkg::CNT_DASH) || (c <= lim);
  endfunction

  function automatic logic [7:0] cnt_of(input logic [7:0] c);
    cnt_of = (c == cdl_pkg::CNT_DASH) ? 8'h_00 : c;
  endfunction

  always_comb begin
    for (int i = 0; i < NODES; i++) begin
      part[i] = is_part(lr_cnt_r[i], dm_cnt_r[i]);
    end
  end

  cdl_span #(.NODES(NODES)) u_span (
    .i_part(part),
    .o_any(span_any),
    .o_low(span_low),
    .o_high(span_high),
    .o_count(span_cnt)
  );

  assign sel_now = i_level ? i_lvl1_sel : i_lvl0_sel;
  assign words_now = i_level ? i_lvl1_words : i_lvl0_words;
  assign auto_mode = sel_now != 2'b00;
  assign auto_lr = 8'(8'h_04 << words_now);
  assign auto_dm = 8'(8'h_08 << words_now);
  assign eff_cycle = (cycle_ms_r == cdl_pkg::CYC_AUTO_MS) ?
    8'(cdl_pkg::CYC_DERIVED_BASE + {2'b00, span_cnt}) : cycle_ms_r;
  assign dm_limit = (family_r == 2'd0) ? cdl_pkg::DM_START_MAX0 :
    (family_r == 2'd1) ? cdl_pkg::DM_START_MAX1 : cdl_pkg::DM_START_MAX2;

  always_comb begin
    total = 16'h_0000;
    for (int i = 0; i < NODES; i++) begin
      total = 16'(total + {8'h_00, cnt_of(lr_cnt_r[i])} + {8'h_00, cnt_of(dm_cnt_r[i])});
    end
  end

  always_comb begin
    if (auto_mode) begin
      cur_cnt = area_r ? (sel_now[1] ? auto_dm : 8'h_00) : (sel_now[0] ? auto_lr : 8'h_00);
    end else begin
      cur_cnt = cnt_of(area_r ? dm_cnt_r[node_r] : lr_cnt_r[node_r]);
    end
  end

  // Control and parameter registers.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      run_r <= 1'b0;
      family_r <= 2'd0;
      reduced_r <= 1'b0;
      cycle_ms_r <= cdl_pkg::CYC_AUTO_MS;
      lr_start_r <= 16'h_0000;
      dm_start_r <= 16'h_0000;
      stat_start_r <= 16'h_0000;
      sel_r <= 6'd0;
      ref_r <= '0;
      copy_r <= 1'b0;
      err_r <= 8'h_00;
    end else begin
      copy_r <= 1'b0;
      if (i_wr) begin
        unique case (i_addr)
          cdl_pkg::A_CTRL: begin
            run_r <= i_wdata[cdl_pkg::CTRL_RUN];
            family_r <= i_wdata[cdl_pkg::CTRL_FAMILY +: 2];
            reduced_r <= i_wdata[cdl_pkg::CTRL_REDUCED];
            copy_r <= i_wdata[cdl_pkg::CTRL_COPY];
          end
          cdl_pkg::A_CYCLE: begin
            if (i_wdata[7:0] == cdl_pkg::CYC_AUTO_MS || i_wdata[7:0] >= cdl_pkg::CYC_MIN_MS) begin
              cycle_ms_r <= i_wdata[7:0];
            end else begin
              err_r[cdl_pkg::ST_ERR_CYCLE] <= 1'b1;
            end
          end
          cdl_pkg::A_LR_START: begin
            if (i_wdata[15:0] <= cdl_pkg::LR_START_MAX) begin
              lr_start_r <= i_wdata[15:0];
            end else begin
              err_r[cdl_pkg::ST_ERR_LR_START] <= 1'b1;
            end
          end
          cdl_pkg::A_DM_START: begin
            if (i_wdata[15:0] <= dm_limit) begin
              dm_start_r <= i_wdata[15:0];
            end else begin
              err_r[cdl_pkg::ST_ERR_DM_START] <= 1'b1;
            end
          end
          cdl_pkg::A_STAT_START: stat_start_r <= i_wdata[15:0];
          cdl_pkg::A_NODE_CNT: begin
            if (!cnt_ok(i_wdata[7:0], cdl_pkg::LR_CNT_MAX) || !cnt_ok(i_wdata[15:8], cdl_pkg::DM_CNT_MAX)) begin
              err_r[cdl_pkg::ST_ERR_CNT] <= 1'b1;
            end
          end
          cdl_pkg::A_STATUS: err_r <= err_r & ~i_wdata[7:0];
          cdl_pkg::A_NODE_SEL: begin
            if (32'(i_wdata[5:0]) < NODES) begin
              sel_r <= i_wdata[5:0];
            end
          end
          cdl_pkg::A_NODE_REF: begin
            if (!i_wdata[0] || part[sel_r]) begin
              ref_r[sel_r] <= i_wdata[0];
            end else begin
              err_r[cdl_pkg::ST_ERR_NODE] <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      if (reduced_r && total > cdl_pkg::REDUCED_SPAN) begin
        err_r[cdl_pkg::ST_ERR_REDUCED] <= 1'b1;
      end
      if (total > cdl_pkg::TOTAL_MAX) begin
        err_r[cdl_pkg::ST_ERR_CNT] <= 1'b1;
      end
    end
  end

  // Per-node word counts, kept apart; reset loops over the arrays to load dash into every entry.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < NODES; i++) begin
        lr_cnt_r[i] <= cdl_pkg::CNT_DASH;
        dm_cnt_r[i] <= cdl_pkg::CNT_DASH;
      end
    end else if (i_wr && i_addr == cdl_pkg::A_NODE_CNT) begin
      if (cnt_ok(i_wdata[7:0], cdl_pkg::LR_CNT_MAX)) begin
        lr_cnt_r[sel_r] <= i_wdata[7:0];
      end
      if (cnt_ok(i_wdata[15:8], cdl_pkg::DM_CNT_MAX)) begin
        dm_cnt_r[sel_r] <= i_wdata[15:8];
      end
    end
  end

  // Read port.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_r <= 32'h_0000_0000;
    end else if (i_rd) begin
      unique case (i_addr)
        cdl_pkg::A_CTRL: rdata_r <= {27'd0, reduced_r, 1'b0, family_r, run_r};
        cdl_pkg::A_CYCLE: rdata_r <= {16'd0, eff_cycle, cycle_ms_r};
        cdl_pkg::A_LR_START: rdata_r <= {16'd0, lr_start_r};
        cdl_pkg::A_DM_START: rdata_r <= {16'd0, dm_start_r};
        cdl_pkg::A_STAT_START: rdata_r <= {16'd0, stat_start_r};
        cdl_pkg::A_STATUS: rdata_r <= {24'd0, (state_r != cdl_pkg::CDL_IDLE), manual_r, err_r[5:0]};
        cdl_pkg::A_SPAN: rdata_r <= {9'd0, span_any, span_cnt, 2'd0, span_high, 2'd0, span_low};
        cdl_pkg::A_NODE_SEL: rdata_r <= {26'd0, sel_r};
        cdl_pkg::A_NODE_CNT: rdata_r <= {16'd0, dm_cnt_r[sel_r], lr_cnt_r[sel_r]};
        cdl_pkg::A_NODE_REF: rdata_r <= {30'd0, part[sel_r], ref_r[sel_r]};
        cdl_pkg::A_AUTO: rdata_r <= {16'd0, auto_dm, auto_lr};
        cdl_pkg::A_RANGE: rdata_r <= {16'd0, total};
        default: rdata_r <= 32'h_0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h_0000_0000;
    end
  end

  // Millisecond timebase and link cycle tick.
  always_ff @(posedge i_clk) begin
    if (i_reset || !run_r) begin
      ms_cnt_r <= 32'd0;
      ms_left_r <= 8'd0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (ms_cnt_r == 32'(MS_CYC - 1)) begin
        ms_cnt_r <= 32'd0;
        if (ms_left_r == 8'd0) begin
          ms_left_r <= 8'(eff_cycle - 8'd1);
          tick_r <= 1'b1;
        end else begin
          ms_left_r <= 8'(ms_left_r - 8'd1);
        end
      end else begin
        ms_cnt_r <= 32'(ms_cnt_r + 32'd1);
      end
    end
  end

  // Refresh scan from lowest to highest participant, both areas, one word per request.
  assign req.node = node_r;
  assign req.is_dm = area_r;
  assign req.word_addr = 16'((area_r ? dm_base_r : lr_base_r) + {8'h_00, word_r});
  assign req.status_addr = 16'(stat_start_r + {10'd0, node_r});
  assign push = (state_r == cdl_pkg::CDL_SCAN) && (word_r < cur_cnt) &&
    (auto_mode || ref_r[node_r]);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= cdl_pkg::CDL_IDLE;
      node_r <= 6'd0;
      area_r <= 1'b0;
      word_r <= 8'd0;
      lr_base_r <= 16'h_0000;
      dm_base_r <= 16'h_0000;
    end else begin
      unique case (state_r)
        cdl_pkg::CDL_IDLE: begin
          if (tick_r && span_any) begin
            state_r <= cdl_pkg::CDL_SCAN;
            node_r <= span_low;
            area_r <= 1'b0;
            word_r <= 8'd0;
            // Automatic tables place each node by its number, so skipped low nodes still take room.
            lr_base_r <= auto_mode ? 16'(lr_start_r + 16'(span_low) * 16'(auto_lr)) : lr_start_r;
            dm_base_r <= auto_mode ? 16'(dm_start_r + 16'(span_low) * 16'(auto_dm)) : dm_start_r;
          end
        end
        cdl_pkg::CDL_SCAN: begin
          if (push && !buf_ready) begin
            state_r <= cdl_pkg::CDL_SCAN;
          end else if (push && word_r != 8'(cur_cnt - 8'd1)) begin
            word_r <= 8'(word_r + 8'd1);
          end else begin
            word_r <= 8'd0;
            if (area_r) begin
              dm_base_r <= 16'(dm_base_r + {8'h_00, cur_cnt});
            end else begin
              lr_base_r <= 16'(lr_base_r + {8'h_00, cur_cnt});
            end
            area_r <= ~area_r;
            if (area_r) begin
              if (node_r >= span_high) begin
                state_r <= cdl_pkg::CDL_WAIT;
              end else begin
                node_r <= 6'(node_r + 6'd1);
              end
            end
          end
        end
        cdl_pkg::CDL_WAIT: state_r <= cdl_pkg::CDL_IDLE;
        default: state_r <= cdl_pkg::CDL_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      manual_r <= 1'b0;
    end else begin
      manual_r <= !auto_mode;
    end
  end

  cdl_fifo2 #(.WIDTH($bits(cdl_pkg::cdl_req_s))) u_buf (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_valid(push),
    .o_ready(buf_ready),
    .i_data(req),
    .o_valid(o_req_valid),
    .i_ready(i_req_ready),
    .o_data(o_req)
  );

  assign o_rdata = rdata_r;
  assign o_cycle_tick = tick_r;
  assign o_copy_req = copy_r;
  assign o_manual = manual_r;
endmodule // cdl_refresh
`default_nettype wire

// ---- testbench/cdl_refresh_monitor.sv ----
// Concurrent checks on the ports of the refresh block top.
`default_nettype none
module cdl_refresh_monitor #(
  parameter int unsigned MS_CYC = 10
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_level,
  input wire logic [1:0] i_lvl0_sel,
  input wire logic [1:0] i_lvl1_sel,
  input wire logic o_req_valid,
  input wire logic i_req_ready,
  input wire cdl_pkg::cdl_req_s o_req,
  input wire logic o_cycle_tick,
  input wire logic o_copy_req,
  input wire logic o_manual
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  logic [15:0] gap_r;
  logic seen_r;
  logic sel_zero;
  assign sel_zero = ((i_level ? i_lvl1_sel : i_lvl0_sel) == 2'b00);
  // Counts cycles since the last cycle start so the minimum period can be checked.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gap_r <= 16'h_0000;
      seen_r <= 1'b0;
    end else if (o_cycle_tick) begin
      gap_r <= 16'h_0000;
      seen_r <= 1'b1;
    end else if (gap_r != 16'h_ffff) begin
      gap_r <= gap_r + 16'h_0001;
    end
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h_0000_0000)
    else $error("read data not zero outside a read answer");
  stall_hold_a: assert property (o_req_valid && !i_req_ready |=> o_req_valid && $stable(o_req))
    else $error("request dropped or changed while stalled");
  tick_pulse_a: assert property (o_cycle_tick |=> !o_cycle_tick)
    else $error("cycle tick longer than one cycle");
  tick_gap_a: assert property (o_cycle_tick && seen_r |-> gap_r >= 16'(5 * MS_CYC - 1))
    else $error("link cycle shorter than the minimum");
  copy_pulse_a: assert property (o_copy_req |=> !o_copy_req)
    else $error("copy request longer than one cycle");
  copy_cause_a: assert property (i_wr && i_addr == cdl_pkg::A_CTRL && i_wdata[cdl_pkg::CTRL_COPY]
    |-> ##[1:2] o_copy_req)
    else $error("copy request missing after copy command");
  manual_on_a: assert property (sel_zero [*3] |-> o_manual)
    else $error("manual tables not flagged with both selects clear");
  manual_off_a: assert property (!sel_zero [*3] |-> !o_manual)
    else $error("manual tables flagged with a select set");
  cover property (o_req_valid && !i_req_ready);
  cover property (o_cycle_tick);
  cover property (o_copy_req);
endmodule // cdl_refresh_monitor

bind cdl_refresh cdl_refresh_monitor #(.MS_CYC(MS_CYC)) u_mon (
  .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_level(i_level), .i_lvl0_sel(i_lvl0_sel), .i_lvl1_sel(i_lvl1_sel),
  .o_req_valid(o_req_valid), .i_req_ready(i_req_ready), .o_req(o_req), .o_cycle_tick(o_cycle_tick),
  .o_copy_req(o_copy_req), .o_manual(o_manual)
);
`default_nettype wire

// ---- testbench/cdl_sink.sv ----
// Far-side node model that takes refresh requests and can stall.
`default_nettype none
module cdl_sink (
  input wire logic i_clk, // clock
  input wire logic i_reset, // synchronous reset
  input wire logic i_stall, // stall two cycles in four
  input wire logic i_valid, // request valid
  input wire cdl_pkg::cdl_req_s i_req, // request
  output logic o_ready, // ready to take
  output logic [15:0] o_count, // requests taken
  output logic [5:0] o_low, // lowest node taken
  output logic [5:0] o_high // highest node taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  assign o_ready = !(i_stall && ph_r[1]);
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ph_r <= 2'b00;
      o_count <= 16'h_0000;
      o_low <= 6'h_3f;
      o_high <= 6'h_00;
    end else begin
      ph_r <= ph_r + 2'b01;
      if (i_valid && o_ready) begin
        o_count <= o_count + 16'h_0001;
        if (i_req.node < o_low) begin
          o_low <= i_req.node;
        end
        if (i_req.node > o_high) begin
          o_high <= i_req.node;
        end
      end
    end
  end
endmodule // cdl_sink
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the refresh block with a far-side node model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MS = 10;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_addr = 8'h_00;
  logic [31:0] i_wdata = 32'h_0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_level = 1'b0;
  logic [1:0] i_lvl0_sel = 2'b00;
  logic [1:0] i_lvl1_sel = 2'b01;
  logic [1:0] i_lvl0_words = 2'b01;
  logic [1:0] i_lvl1_words = 2'b00;
  logic stall = 1'b0;
  logic [31:0] o_rdata;
  logic o_req_valid;
  logic req_ready;
  cdl_pkg::cdl_req_s o_req;
  logic o_cycle_tick;
  logic o_copy_req;
  logic o_manual;
  logic [15:0] got_cnt;
  logic [5:0] got_low;
  logic [5:0] got_high;
  int miscompares = 0;
  int total_checks = 0;
  int copies = 0;
  cdl_pkg::cdl_req_s first_req;
  logic first_seen = 1'b0;
  logic [15:0] lim [3] = '{cdl_pkg::DM_START_MAX0, cdl_pkg::DM_START_MAX1, cdl_pkg::DM_START_MAX2};
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_copy_req === 1'b1) begin
      copies++;
    end
  end
  // Keeps the first request that the far side takes.
  always @(posedge i_clk) begin
    if (!first_seen && o_req_valid === 1'b1 && req_ready === 1'b1) begin
      first_req <= o_req;
      first_seen <= 1'b1;
    end
  end
  cdl_refresh #(.NODES(62), .MS_CYC(MS)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_level(i_level), .i_lvl0_sel(i_lvl0_sel), .i_lvl1_sel(i_lvl1_sel),
    .i_lvl0_words(i_lvl0_words), .i_lvl1_words(i_lvl1_words), .o_req_valid(o_req_valid),
    .i_req_ready(req_ready), .o_req(o_req), .o_cycle_tick(o_cycle_tick), .o_copy_req(o_copy_req),
    .o_manual(o_manual)
  );
  cdl_sink u_sink (
    .i_clk(i_clk), .i_reset(i_reset), .i_stall(stall), .i_valid(o_req_valid), .i_req(o_req),
    .o_ready(req_ready), .o_count(got_cnt), .o_low(got_low), .o_high(got_high)
  );
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    cmp(o_rdata & m, e);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    int n;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    wr(cdl_pkg::A_NODE_SEL, 32'h_0000_0002);
    rdc(cdl_pkg::A_NODE_CNT, 32'h_0000_ffff, 32'h_0000_ffff);
    done("reset");
    wr(cdl_pkg::A_LR_START, 32'h_0000_003f);
    rdc(cdl_pkg::A_LR_START, 32'h_0000_ffff, 32'h_0000_003f);
    wr(cdl_pkg::A_LR_START, 32'h_0000_0040);
    rdc(cdl_pkg::A_LR_START, 32'h_0000_ffff, 32'h_0000_003f);
    rdc(cdl_pkg::A_STATUS, 32'h_0000_0001, 32'h_0000_0001);
    wr(cdl_pkg::A_STATUS, 32'h_0000_00ff);
    wr(cdl_pkg::A_STAT_START, 32'h_0000_00c8);
    rdc(cdl_pkg::A_STAT_START, 32'h_0000_ffff, 32'h_0000_00c8);
    done("start words");
    wr(cdl_pkg::A_CYCLE, 32'h_0000_00ff);
    wr(cdl_pkg::A_CYCLE, 32'h_0000_0004);
    rdc(cdl_pkg::A_CYCLE, 32'h_0000_00ff, 32'h_0000_00ff);
    rdc(cdl_pkg::A_STATUS, 32'h_0000_0004, 32'h_0000_0004);
    wr(cdl_pkg::A_STATUS, 32'h_0000_00ff);
    wr(cdl_pkg::A_CYCLE, 32'h_0000_0005);
    rdc(cdl_pkg::A_CYCLE, 32'h_0000_00ff, 32'h_0000_0005);
    done("cycle time");
    for (int f = 0; f < 3; f++) begin
      wr(cdl_pkg::A_CTRL, 32'(f) << cdl_pkg::CTRL_FAMILY);
      wr(cdl_pkg::A_DM_START, {16'h_0000, lim[f]});
      rdc(cdl_pkg::A_DM_START, 32'h_0000_ffff, {16'h_0000, lim[f]});
      wr(cdl_pkg::A_DM_START, {16'h_0000, lim[f] + 16'h_0001});
      rdc(cdl_pkg::A_DM_START, 32'h_0000_ffff, {16'h_0000, lim[f]});
      rdc(cdl_pkg::A_STATUS, 32'h_0000_0002, 32'h_0000_0002);
      wr(cdl_pkg::A_STATUS, 32'h_0000_00ff);
    end
    done("data memory start");
    wr(cdl_pkg::A_NODE_CNT, 32'h_0000_fe40);
    rdc(cdl_pkg::A_NODE_CNT, 32'h_0000_ffff, 32'h_0000_fe40);
    wr(cdl_pkg::A_NODE_CNT, 32'h_0000_ff41);
    rdc(cdl_pkg::A_NODE_CNT, 32'h_0000_ffff, 32'h_0000_ff40);
    rdc(cdl_pkg::A_STATUS, 32'h_0000_0010, 32'h_0000_0010);
    wr(cdl_pkg::A_STATUS, 32'h_0000_00ff);
    foreach (lim[i]) begin
      n = (i == 0) ? 2 : i + 3;
      wr(cdl_pkg::A_NODE_SEL, 32'(n));
      wr(cdl_pkg::A_NODE_CNT, 32'h_0000_ff08);
      wr(cdl_pkg::A_NODE_REF, 32'h_0000_0001);
    end
    wr(cdl_pkg::A_NODE_SEL, 32'h_0000_0006);
    wr(cdl_pkg::A_NODE_CNT, 32'h_0000_ff08);
    wr(cdl_pkg::A_NODE_REF, 32'h_0000_0001);
    rdc(cdl_pkg::A_NODE_REF, 32'h_0000_0003, 32'h_0000_0003);
    wr(cdl_pkg::A_NODE_SEL, 32'h_0000_0003);
    wr(cdl_pkg::A_NODE_REF, 32'h_0000_0001);
    rdc(cdl_pkg::A_NODE_REF, 32'h_0000_0003, 32'h_0000_0000);
    rdc(cdl_pkg::A_STATUS, 32'h_0000_0008, 32'h_0000_0008);
    wr(cdl_pkg::A_STATUS, 32'h_0000_00ff);
    wr(cdl_pkg::A_CYCLE, 32'h_0000_0000);
    rdc(cdl_pkg::A_CYCLE, 32'h_0000_ff00, 32'h_0000_0900);
    wr(cdl_pkg::A_CYCLE, 32'h_0000_0005);
    done("node tables");
    @(posedge i_clk);
    i_level <= 1'b1;
    repeat (4) @(posedge i_clk);
    cmp({31'h_0, o_manual}, 32'h_0000_0000);
    rdc(cdl_pkg::A_STATUS, 32'h_0000_0040, 32'h_0000_0000);
    i_level <= 1'b0;
    repeat (4) @(posedge i_clk);
    cmp({31'h_0, o_manual}, 32'h_0000_0001);
    rdc(cdl_pkg::A_STATUS, 32'h_0000_0040, 32'h_0000_0040);
    wr(cdl_pkg::A_CTRL, 32'h_0000_0008);
    repeat (3) @(posedge i_clk);
    cmp(32'(copies), 32'h_0000_0001);
    done("level and copy");
    stall <= 1'b1;
    wr(cdl_pkg::A_CTRL, 32'h_0000_0011);
    n = 0;
    while (got_cnt < 16'h_0008 && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 4000) begin
      miscompares++;
      close_out();
    end
    repeat (300) @(posedge i_clk);
    cmp({26'h_0, got_low}, 32'h_0000_0002);
    cmp({26'h_0, got_high}, 32'h_0000_0006);
    cmp({first_req.word_addr, first_req.status_addr}, 32'h_003f_00ca);
    rdc(cdl_pkg::A_SPAN, 32'h_ffff_ffff, 32'h_0044_0602);
    rdc(cdl_pkg::A_RANGE, 32'h_0000_ffff, 32'h_0000_0020);
    rdc(cdl_pkg::A_STATUS, 32'h_0000_0020, 32'h_0000_0000);
    done("refresh scan");
    close_out();
  end
endmodule // tb
`default_nettype wire
